/* hw/crsw_defines.svh */
/*
  Register offsets, field positions, reset values and value limits of the
  counter read-back block. Assumes it is included by bare name, once or more.
*/
`ifndef CRSW_DEFINES_SVH
`define CRSW_DEFINES_SVH

// APB byte offsets, one 32-bit word each
`define CRSW_OFF_CMD       8'h00
`define CRSW_OFF_WDATA     8'h04
`define CRSW_OFF_WCOND     8'h08
`define CRSW_OFF_RB_LO     8'h0c
`define CRSW_OFF_RB_HI     8'h10
`define CRSW_OFF_STATUS    8'h14
`define CRSW_OFF_RB_COND   8'h18
`define CRSW_OFF_IRQ_ST    8'h1c
`define CRSW_OFF_IRQ_MASK  8'h20

// Command word bits
`define CRSW_CMD_SV1_WR    0
`define CRSW_CMD_SV2_WR    1
`define CRSW_CMD_CNT_WR    2
`define CRSW_CMD_HEX       3
`define CRSW_CMD_SV1_RD    4
`define CRSW_CMD_SV2_RD    5
`define CRSW_CMD_CNT_RD    6
`define CRSW_CMD_OUT1_EN   8
`define CRSW_CMD_OUT2_EN   9
`define CRSW_CMD_MASK      16'h037f

// Status word bits
`define CRSW_ST_SV1_DONE   0
`define CRSW_ST_SV2_DONE   1
`define CRSW_ST_CNT_DONE   2
`define CRSW_ST_HEX        3
`define CRSW_ST_SV1_HELD   4
`define CRSW_ST_SV2_HELD   5
`define CRSW_ST_CNT_HELD   6
`define CRSW_ST_RUNNING    7
`define CRSW_ST_OUT1       8
`define CRSW_ST_OUT2       9
`define CRSW_ST_SET_ERR    13

// Reset values
`define CRSW_RST_CMD       16'h0000
`define CRSW_RST_MASK      4'h0

// Value limits and encodings
`define CRSW_MAG_MAX_POS   32'h007f_ffff
`define CRSW_MAG_MAX_NEG   32'h0080_0000
`define CRSW_BCD_NEG_SIGN  4'hf
`define CRSW_COND_GE       3'h0

`endif

/* hw/crsw_pkg.sv */
/*
  Types of the counter read-back block: the served-command enum and the
  packed state struct. Assumes the defines header sits beside it.
*/
`default_nettype none
package crsw_pkg;

  // Command served in a cycle: none first, then the commands highest priority first
  typedef enum logic [2:0] {
    SRV_NONE, SRV_SV1_WR, SRV_SV2_WR, SRV_CNT_WR, SRV_SV1_RD, SRV_SV2_RD, SRV_CNT_RD
  } crsw_srv_e;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cmd;       // Command word
    logic [31:0] wdata;     // Value to write, in current format
    logic [2:0]  wcond;     // Output condition to write
    logic [23:0] sv1;       // Set value 1
    logic [23:0] sv2;       // Set value 2
    logic [2:0]  cond1;     // Condition of set value 1
    logic [2:0]  cond2;     // Condition of set value 2
    logic [15:0] rb_lo;     // Read-back low word
    logic [15:0] rb_hi;     // Read-back high word
    logic [2:0]  rb_cond;   // Condition of the value read back
    logic [15:0] status;    // Status word
    logic [3:0]  irq_st;    // Sticky events
    logic [3:0]  irq_mask;  // Event enables
    logic        irq;       // Interrupt level
    logic        pready;    // APB ready
    logic        pslverr;   // APB error
    logic [31:0] prdata;    // APB read data
    logic [1:0]  ext_out;   // Gated comparison outputs
    logic        load;      // Count load strobe
    logic [23:0] load_val;  // Count load value
  } crsw_state_s;

endpackage
`default_nettype wire

/* hw/crsw_readback.sv */
/*
  Counter read-back and status block: command word, set values, read-back
  words in BCD or hex, status word, comparison outputs and an interrupt, all
  reached over APB. Assumes the counting engine runs on the same clock and
  gives its present value and run state without any crossing.
*/
// Our own choices: the APB register port and the register offsets.
`default_nettype none
`include "crsw_defines.svh"

module crsw_readback
  import crsw_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Counting engine
  input  wire logic [23:0]       i_count_value,
  input  wire logic              i_count_running,
  output logic                   o_count_load,
  output logic      [23:0]       o_count_load_value,
  // Outputs and interrupt
  output logic      [1:0]        o_ext_out,
  output logic                   o_irq
);

  crsw_state_s st_ff;   // Registered state
  crsw_state_s nxt_st;  // Next state
  crsw_srv_e   served;  // Command served this cycle
  logic [24:0] parsed;  // {error, value} of the pending write

  // Present value to BCD or hex: two words, hex keeps only six digits
  function automatic logic [31:0] crsw_fmt(input logic [23:0] v, input logic hex);
    logic [23:0] mag;
    logic [27:0] bcd;
    int          i;
    int          j;
    mag = v[23] ? 24'(-v) : v;
    bcd = '0;
    for (i = 23; i >= 0; i--)
    begin
      for (j = 0; j < 7; j++)
      begin
        if (bcd[4*j+:4] >= 4'h5)
          bcd[4*j+:4] = bcd[4*j+:4] + 4'h3;
      end
      bcd = {bcd[26:0], mag[i]};
    end
    if (hex)
      return {8'h00, v};
    return {(v[23] ? `CRSW_BCD_NEG_SIGN : 4'h0), bcd};
  endfunction

  // Written word to value plus an error bit for range or format faults
  function automatic logic [24:0] crsw_parse(input logic [31:0] w, input logic hex);
    logic [31:0] mag;
    logic        err;
    logic        neg;
    int          k;
    mag = '0;
    neg = (w[31:28] == `CRSW_BCD_NEG_SIGN);
    if (hex)
      return {(w[31:24] != 8'h00), w[23:0]};
    err = (w[31:28] != 4'h0) && !neg;
    for (k = 6; k >= 0; k--)
    begin
      err = err | (w[4*k+:4] > 4'h9);
      mag = 32'(mag * 32'd10) + {28'h0, w[4*k+:4]};
    end
    // Negative span reaches one further than the positive one
    err = err | (neg ? (mag > `CRSW_MAG_MAX_NEG) : (mag > `CRSW_MAG_MAX_POS));
    return {err, (neg ? 24'(-mag) : mag[23:0])};
  endfunction

  // Next-state logic: bus, command service, comparisons and interrupt
  always_comb
  begin
    logic [15:0] cmd;
    logic [31:0] word;
    logic [3:0]  ev;
    logic [1:0]  cmp;
    cmd    = st_ff.cmd;
    word   = '0;
    ev     = '0;
    cmp    = '0;
    nxt_st = st_ff;
    served = SRV_NONE;
    parsed = crsw_parse(st_ff.wdata, cmd[`CRSW_CMD_HEX]);

    // APB: answer in the first access cycle, data and error set in setup
    nxt_st.pready  = i_psel && !i_penable;
    nxt_st.pslverr = 1'b0;
    nxt_st.load    = 1'b0;
    if (i_psel && !i_penable)
    begin
      nxt_st.prdata = '0;
      case (8'(i_paddr))
        `CRSW_OFF_CMD:      nxt_st.prdata = {16'h0, st_ff.cmd};
        `CRSW_OFF_WDATA:    nxt_st.prdata = st_ff.wdata;
        `CRSW_OFF_WCOND:    nxt_st.prdata = {29'h0, st_ff.wcond};
        `CRSW_OFF_RB_LO:    nxt_st.prdata = {16'h0, st_ff.rb_lo};
        `CRSW_OFF_RB_HI:    nxt_st.prdata = {16'h0, st_ff.rb_hi};
        `CRSW_OFF_STATUS:   nxt_st.prdata = {16'h0, st_ff.status};
        `CRSW_OFF_RB_COND:  nxt_st.prdata = {29'h0, st_ff.rb_cond};
        `CRSW_OFF_IRQ_ST:   nxt_st.prdata = {28'h0, st_ff.irq_st};
        `CRSW_OFF_IRQ_MASK: nxt_st.prdata = {28'h0, st_ff.irq_mask};
        default:            nxt_st.pslverr = 1'b1;  // Unmapped address
      endcase
    end

    // APB write takes effect on the completing edge only
    if (i_psel && i_penable && st_ff.pready && i_pwrite)
    begin
      case (8'(i_paddr))
        `CRSW_OFF_CMD:      nxt_st.cmd = i_pwdata[15:0] & `CRSW_CMD_MASK;
        `CRSW_OFF_WDATA:    nxt_st.wdata = i_pwdata;
        `CRSW_OFF_WCOND:    nxt_st.wcond = i_pwdata[2:0];
        `CRSW_OFF_IRQ_ST:   nxt_st.irq_st = st_ff.irq_st & ~i_pwdata[3:0];
        `CRSW_OFF_IRQ_MASK: nxt_st.irq_mask = i_pwdata[3:0];
        default:            nxt_st.cmd = st_ff.cmd;  // Read-only or unmapped
      endcase
    end

    // Pick one command: pending writes first, then held reads
    if (cmd[`CRSW_CMD_SV1_WR] && !st_ff.status[`CRSW_ST_SV1_DONE])
      served = SRV_SV1_WR;
    else if (cmd[`CRSW_CMD_SV2_WR] && !st_ff.status[`CRSW_ST_SV2_DONE])
      served = SRV_SV2_WR;
    else if (cmd[`CRSW_CMD_CNT_WR] && !st_ff.status[`CRSW_ST_CNT_DONE])
      served = SRV_CNT_WR;
    else if (cmd[`CRSW_CMD_SV1_RD])
      served = SRV_SV1_RD;
    else if (cmd[`CRSW_CMD_SV2_RD])
      served = SRV_SV2_RD;
    else if (cmd[`CRSW_CMD_CNT_RD])
      served = SRV_CNT_RD;

    // Completion flags drop with their command bit
    if (!cmd[`CRSW_CMD_SV1_WR])
      nxt_st.status[`CRSW_ST_SV1_DONE] = 1'b0;
    if (!cmd[`CRSW_CMD_SV2_WR])
      nxt_st.status[`CRSW_ST_SV2_DONE] = 1'b0;
    if (!cmd[`CRSW_CMD_CNT_WR])
      nxt_st.status[`CRSW_ST_CNT_DONE] = 1'b0;
    // Stored flags hold only while their read is the one served
    nxt_st.status[`CRSW_ST_CNT_HELD:`CRSW_ST_SV1_HELD] = 3'b000;

    // Serve the chosen command
    case (served)
      SRV_SV1_WR:
      begin
        nxt_st.status[`CRSW_ST_SV1_DONE] = 1'b1;
        nxt_st.status[`CRSW_ST_SV2_DONE] = 1'b0;
        nxt_st.status[`CRSW_ST_SET_ERR]  = parsed[24];
        if (!parsed[24])
        begin
          nxt_st.sv1   = parsed[23:0];
          nxt_st.cond1 = st_ff.wcond;
        end
      end
      SRV_SV2_WR:
      begin
        nxt_st.status[`CRSW_ST_SV2_DONE] = 1'b1;
        nxt_st.status[`CRSW_ST_SET_ERR]  = parsed[24];
        if (!parsed[24])
        begin
          nxt_st.sv2   = parsed[23:0];
          nxt_st.cond2 = st_ff.wcond;
        end
      end
      SRV_CNT_WR:
      begin
        // A count write never clears the set-value flags above it
        nxt_st.status[`CRSW_ST_CNT_DONE] = 1'b1;
        nxt_st.status[`CRSW_ST_SET_ERR]  = parsed[24];
        nxt_st.load     = !parsed[24];
        nxt_st.load_val = parsed[23:0];
      end
      SRV_SV1_RD:
      begin
        word = crsw_fmt(st_ff.sv1, cmd[`CRSW_CMD_HEX]);
        nxt_st.rb_cond = st_ff.cond1;
        nxt_st.status[`CRSW_ST_SV1_HELD] = 1'b1;
      end
      SRV_SV2_RD:
      begin
        word = crsw_fmt(st_ff.sv2, cmd[`CRSW_CMD_HEX]);
        nxt_st.rb_cond = st_ff.cond2;
        nxt_st.status[`CRSW_ST_SV2_HELD] = 1'b1;
      end
      SRV_CNT_RD:
      begin
        word = crsw_fmt(i_count_value, cmd[`CRSW_CMD_HEX]);
        nxt_st.rb_cond = `CRSW_COND_GE;
        nxt_st.status[`CRSW_ST_CNT_HELD] = 1'b1;
      end
      default:
        word = '0;  // Idle: read-back words keep their last value
    endcase
    if (served inside {SRV_SV1_RD, SRV_SV2_RD, SRV_CNT_RD})
    begin
      nxt_st.rb_lo = word[15:0];
      nxt_st.rb_hi = word[31:16];
    end

    // Comparisons, gated by the enables before they reach the pins
    cmp[0] = (st_ff.cond1 == `CRSW_COND_GE) ? ($signed(i_count_value) >= $signed(st_ff.sv1))
                                            : ($signed(i_count_value) <= $signed(st_ff.sv1));
    cmp[1] = (st_ff.cond2 == `CRSW_COND_GE) ? ($signed(i_count_value) >= $signed(st_ff.sv2))
                                            : ($signed(i_count_value) <= $signed(st_ff.sv2));
    nxt_st.ext_out = cmp & {cmd[`CRSW_CMD_OUT2_EN], cmd[`CRSW_CMD_OUT1_EN]};
    nxt_st.status[`CRSW_ST_OUT2:`CRSW_ST_OUT1] = nxt_st.ext_out;
    nxt_st.status[`CRSW_ST_HEX]     = cmd[`CRSW_CMD_HEX];
    nxt_st.status[`CRSW_ST_RUNNING] = i_count_running;

    // Rising completion and error flags set sticky bits; set beats clear
    ev[2:0] = nxt_st.status[2:0] & ~st_ff.status[2:0];
    ev[3]   = nxt_st.status[`CRSW_ST_SET_ERR] & ~st_ff.status[`CRSW_ST_SET_ERR];
    nxt_st.irq_st = nxt_st.irq_st | ev;
    nxt_st.irq    = |(nxt_st.irq_st & nxt_st.irq_mask);
  end

  // State register, synchronous reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff          <= '0;
      st_ff.cmd      <= `CRSW_RST_CMD;
      st_ff.irq_mask <= `CRSW_RST_MASK;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign o_prdata           = st_ff.prdata;
  assign o_pready           = st_ff.pready;
  assign o_pslverr          = st_ff.pslverr;
  assign o_count_load       = st_ff.load;
  assign o_count_load_value = st_ff.load_val;
  assign o_ext_out          = st_ff.ext_out;
  assign o_irq              = st_ff.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_ext_out_gate: assert property (!st_ff.cmd[`CRSW_CMD_OUT1_EN] |=> !o_ext_out[0])
    else $error("output 1 driven while disabled");
  a_cmp_ge_on: assert property ((st_ff.cmd[`CRSW_CMD_OUT1_EN] && st_ff.cond1 == 3'h0
    && $signed(i_count_value) >= $signed(st_ff.sv1)) |=> o_ext_out[0])
    else $error("greater-or-equal comparison missed");
  a_sv1_done_drop: assert property (!st_ff.cmd[0] |=> !st_ff.status[0])
    else $error("set value 1 done flag outlived command");
  a_sv2_done_set: assert property (served == SRV_SV2_WR |=> st_ff.status[1])
    else $error("set value 2 done flag not set");
  a_cnt_done_hold: assert property ((st_ff.status[2] && st_ff.cmd[2]) |=> st_ff.status[2])
    else $error("count done flag cleared while command held");
  a_err_on_bad: assert property ((served inside {SRV_SV1_WR, SRV_SV2_WR, SRV_CNT_WR})
    |=> st_ff.status[13] == $past(parsed[24]))
    else $error("setting error flag wrong after write");
  a_hex_twos: assert property ((served == SRV_CNT_RD && st_ff.cmd[3])
    |=> {st_ff.rb_hi, st_ff.rb_lo} == {8'h00, $past(i_count_value)})
    else $error("hex read-back not 24-bit two's complement");
  a_bcd_sign: assert property ((served == SRV_CNT_RD && !st_ff.cmd[3]
    && i_count_value[23])
    |=> st_ff.rb_hi[15:12] == 4'hf)
    else $error("BCD negative sign nibble missing");
  a_code_flag: assert property (##1 st_ff.status[3] == $past(st_ff.cmd[3]))
    else $error("data code flag does not follow command");
  a_run_flag: assert property (##1 st_ff.status[7] == $past(i_count_running))
    else $error("running flag does not follow counter");
  a_one_stored: assert property ($onehot0(st_ff.status[6:4]))
    else $error("more than one stored flag set");
  a_sv1_stored: assert property (served == SRV_SV1_RD |=> st_ff.status[4])
    else $error("set value 1 stored flag missing");
  a_sv2_stored: assert property (served == SRV_SV2_RD |=> st_ff.status[5])
    else $error("set value 2 stored flag missing");
  a_cnt_stored: assert property (served == SRV_CNT_RD |=> st_ff.status[6])
    else $error("count stored flag missing");
  a_sv_refresh: assert property ((served == SRV_SV1_RD && st_ff.cmd[`CRSW_CMD_HEX])
    |=> {st_ff.rb_hi, st_ff.rb_lo} == {8'h00, $past(st_ff.sv1)})
    else $error("held set value read not refreshed");
  a_apb_answer: assert property ((i_psel && !i_penable) |=> (o_pready ##1 !o_pready))
    else $error("APB answer not one access cycle");

  c_sv1_write: cover property (served == SRV_SV1_WR ##1 st_ff.status[0]);
  c_bad_write: cover property (served == SRV_CNT_WR && parsed[24]);
  c_hex_read: cover property (served == SRV_CNT_RD && st_ff.cmd[3]);
  c_irq_rise: cover property (!o_irq ##1 o_irq);

endmodule  // crsw_readback
`default_nettype wire

/* testbench/crsw_count_engine.sv */
/*
  Behavioural counting engine on the far side of the read-back block.
  Assumes the block's clock and synchronous active-low reset.
*/
`default_nettype none
module crsw_count_engine
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Control from bench and block
  input  wire logic        i_run,
  input  wire logic        i_load,
  input  wire logic [23:0] i_load_value,
  // Present value and run state
  output logic      [23:0] o_count_value,
  output logic             o_count_running
);
  timeunit 1ns;
  timeprecision 1ps;

  // Load beats counting so a written value is never lost to an increment
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_count_value   <= 24'h000000;
      o_count_running <= 1'b0;
    end
    else
    begin
      o_count_running <= i_run;
      if (i_load)
        o_count_value <= i_load_value;
      else if (i_run)
        o_count_value <= o_count_value + 24'h000001;
    end
  end
endmodule // crsw_count_engine
`default_nettype wire

/* testbench/counter_readback_status_word_test.sv */
/*
  Self-checking bench of the read-back block: APB master tasks and a
  sequence of register accesses with expected values.
  Assumes the defines header and the package are compiled first.
*/
`default_nettype none
`include "crsw_defines.svh"
module counter_readback_status_word_test
  import crsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;       // Bench clock
  logic        rst_n;         // Reset, active low
  logic        psel;          // APB select
  logic        penable;       // APB enable
  logic        pwrite;        // APB direction
  logic [7:0]  paddr;         // APB address
  logic [31:0] pwdata;        // APB write data
  logic [31:0] prdata;        // APB read data
  logic        pready;        // APB ready
  logic        pslverr;       // APB error
  logic        run;           // Run request to the engine
  logic        count_load;    // Load strobe from block
  logic [23:0] load_value;    // Load value from block
  logic [23:0] count_value;   // Engine value
  logic        count_running; // Engine run state
  logic [1:0]  ext_out;       // Gated comparison outputs
  logic        irq;           // Interrupt level
  logic [31:0] rdq;           // Last read data
  logic        err_seen;      // Last error response
  int          miscompares;   // Mismatch count
  int          n_tests;       // Comparison count

  crsw_readback i_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_count_value(count_value),
    .i_count_running(count_running), .o_count_load(count_load),
    .o_count_load_value(load_value), .o_ext_out(ext_out), .o_irq(irq));

  crsw_count_engine i_engine (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_run(run), .i_load(count_load),
    .i_load_value(load_value), .o_count_value(count_value),
    .o_count_running(count_running));

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Single exit of the run
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
    begin
      n++;
      // A slave that never answers ends the run
      if (n > 20)
      begin
        miscompares++;
        give_verdict();
      end
      @(posedge sys_clk);
    end
    rdq      = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdq);
  endtask

  // Command write, then the fixed two-edge service delay plus margin
  task automatic cmd(input logic [15:0] c);
    wr(`CRSW_OFF_CMD, {16'h0000, c});
    repeat (3) @(posedge sys_clk);
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; run = 1'b0; miscompares = 0; n_tests = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd("cmd", `CRSW_OFF_CMD, 32'h0);
    rd("mask", `CRSW_OFF_IRQ_MASK, 32'h0);
    rd("status", `CRSW_OFF_STATUS, 32'h0);
    // Hex negative into set value 1
    wr(`CRSW_OFF_WDATA, 32'h00ff_d8f0);
    wr(`CRSW_OFF_WCOND, 32'h0);
    cmd(16'h0009);
    rd("status", `CRSW_OFF_STATUS, 32'h0009);
    cmd(16'h0018);
    rd("status", `CRSW_OFF_STATUS, 32'h0018);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'h00ff);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'hd8f0);
    rd("rb_cond", `CRSW_OFF_RB_COND, 32'h0);
    // BCD minimum into set value 2 with a non-zero condition
    wr(`CRSW_OFF_WDATA, 32'hf838_8608);
    wr(`CRSW_OFF_WCOND, 32'h5);
    cmd(16'h0002);
    rd("status", `CRSW_OFF_STATUS, 32'h0002);
    cmd(16'h0020);
    rd("status", `CRSW_OFF_STATUS, 32'h0020);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'hf838);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h8608);
    rd("rb_cond", `CRSW_OFF_RB_COND, 32'h5);
    cmd(16'h0028);
    rd("status", `CRSW_OFF_STATUS, 32'h0028);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'h0080);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h0000);
    cmd(16'h0010);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'hf001);
    // Out-of-range write while set value 1 is read back
    wr(`CRSW_OFF_IRQ_ST, 32'hf);
    wr(`CRSW_OFF_WDATA, 32'h0838_8608);
    cmd(16'h0011);
    rd("status", `CRSW_OFF_STATUS, 32'h2011);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'hf001);
    rd("irq_st", `CRSW_OFF_IRQ_ST, 32'h9);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`CRSW_OFF_IRQ_MASK, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`CRSW_OFF_IRQ_ST, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd("irq_st", `CRSW_OFF_IRQ_ST, 32'h1);
    // Good write under a held read clears the error and refreshes
    cmd(16'h0010);
    wr(`CRSW_OFF_WDATA, 32'h0000_0456);
    wr(`CRSW_OFF_WCOND, 32'h0);
    cmd(16'h0011);
    rd("status", `CRSW_OFF_STATUS, 32'h0011);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h0456);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'h0000);
    // Count write, then a higher write beside it
    wr(`CRSW_OFF_WDATA, 32'h0000_0064);
    cmd(16'h000c);
    rd("status", `CRSW_OFF_STATUS, 32'h000c);
    wr(`CRSW_OFF_WDATA, 32'h0000_0032);
    cmd(16'h000d);
    rd("status", `CRSW_OFF_STATUS, 32'h000d);
    cmd(16'h0058);
    rd("status", `CRSW_OFF_STATUS, 32'h0018);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h0032);
    cmd(16'h0048);
    rd("status", `CRSW_OFF_STATUS, 32'h0048);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h0064);
    rd("rb_cond", `CRSW_OFF_RB_COND, 32'h0);
    // Comparison outputs: 100 >= 50 on, 100 <= minimum off
    cmd(16'h0348);
    chk("ext_out", 32'h1, {30'h0, ext_out});
    rd("status", `CRSW_OFF_STATUS, 32'h0148);
    cmd(16'h0248);
    chk("ext_out", 32'h0, {30'h0, ext_out});
    // Running flag follows the engine
    run <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd("status", `CRSW_OFF_STATUS, 32'h00c8);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd("status", `CRSW_OFF_STATUS, 32'h0048);
    // Malformed BCD count write, then BCD minus one read back
    wr(`CRSW_OFF_WDATA, 32'h0000_00a0);
    cmd(16'h0004);
    rd("status", `CRSW_OFF_STATUS, 32'h2004);
    cmd(16'h0000);
    wr(`CRSW_OFF_WDATA, 32'hf000_0001);
    cmd(16'h0004);
    rd("status", `CRSW_OFF_STATUS, 32'h0004);
    cmd(16'h0040);
    rd("rb_hi", `CRSW_OFF_RB_HI, 32'hf000);
    rd("rb_lo", `CRSW_OFF_RB_LO, 32'h0001);
    // Set value 2 of zero with a non-zero code: -1 <= 0 drives output 2
    wr(`CRSW_OFF_WDATA, 32'h0000_0000);
    wr(`CRSW_OFF_WCOND, 32'h5);
    cmd(16'h0002);
    cmd(16'h0200);
    chk("ext_out", 32'h2, {30'h0, ext_out});
    rd("status", `CRSW_OFF_STATUS, 32'h0200);
    // Unmapped address answers with an error and zero
    rd("unmapped", 8'h40, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err_seen});
    give_verdict();
  end
endmodule // counter_readback_status_word_test
`default_nettype wire
